// File: rtl/aic_alarm_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module aic_alarm_ctrl
    import aic_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = AIC_TICK_CYCLES,
    parameter int unsigned DS1_PORTS = 8,
    parameter int unsigned DS3_PORTS = 2,
    parameter int unsigned EC1_PORTS = 2,
    parameter int unsigned NUM_PACKS = 8,
    parameter int unsigned NUM_PSU = 2
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [DS1_PORTS+DS3_PORTS+EC1_PORTS-1:0] fac_fail,
    input wire logic ctrl_fail,
    input wire logic audible_cutoff_panel,
    input wire logic audible_cutoff_remote,
    input wire logic [NUM_PACKS-1:0] pack_fail,
    input wire logic [NUM_PSU-1:0] psu_fault,
    output logic [NUM_PSU-1:0] psu_fault_lamp,
    input wire logic [AIC_SYNC_PACKS-1:0] sync_pack_fail,
    input wire logic sync_active_side,
    input wire logic [1:0] sync_mode,
    input wire logic [1:0] ref_fail,
    input wire logic all_ref_fail,
    output logic [AIC_SYNC_PACKS-1:0] fault_lamp,
    output logic [AIC_SYNC_PACKS-1:0] active_lamp,
    output logic [AIC_SYNC_PACKS-1:0] sync_in_service,
    output aic_alarm_t remote_alarm,
    output aic_alarm_t panel_indicator,
    output aic_alarm_t office_visual,
    output aic_alarm_t office_audible,
    output logic remote_id,
    output logic audible_cutoff,
    output logic irq
);

    localparam int unsigned NPORTS = DS1_PORTS + DS3_PORTS + EC1_PORTS;
    localparam int unsigned NALL = NUM_PACKS + AIC_SYNC_PACKS;

    // ------------------------------------------------------------
    // Second tick divider
    // ------------------------------------------------------------
    // Free-running from reset, not aligned to any input, so each timed wait
    // may lose up to one tick period at its start.
    logic [31:0] div_cnt;
    logic [31:0] next_div_cnt;
    logic tick;

    always_comb begin
        tick = (div_cnt == 32'(TICK_CYCLES - 1));
        next_div_cnt = tick ? 32'h0 : div_cnt + 32'h1;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 32'h0;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [AIC_DELAY_W-1:0] delay_s;
    logic [AIC_DELAY_W-1:0] next_delay_s;
    logic [AIC_SW_W-1:0] sw_alarm;
    logic [AIC_SW_W-1:0] next_sw_alarm;
    logic [AIC_LEVEL_W*NPORTS-1:0] port_level;
    logic [AIC_LEVEL_W*NPORTS-1:0] next_port_level;
    logic [AIC_ST_W-1:0] status;
    logic [AIC_ST_W-1:0] next_status;
    logic [AIC_ST_W-1:0] mask;
    logic [AIC_ST_W-1:0] next_mask;
    logic [AIC_ST_W-1:0] st_set;
    logic [AIC_EVENT_W-1:0] events;
    logic [AIC_EVENT_W-1:0] next_events;
    logic [AIC_EVENT_W-1:0] fail_rises;
    logic [31:0] next_rdata;
    logic [31:0] state_word;
    logic wr_ctrl;
    logic wr_sw;
    logic wr_lvl;
    logic wr_st;
    logic wr_mask;

    // Reset levels per port: DS1 ports raise nothing, DS3 and EC-1 ports major.
    // A constant, so the asynchronous reset loads no logic.
    localparam logic [AIC_LEVEL_W*NPORTS-1:0] LEVEL_RST = {
        {(DS3_PORTS + EC1_PORTS){AIC_LVL_MAJOR}},
        {DS1_PORTS{AIC_LVL_NONE}}
    };

    // Writes land at the strobe edge; a read answers in the next cycle only,
    // and the data word falls back to zero after it.
    always_comb begin
        wr_ctrl = reg_wr && (reg_addr == AIC_REG_CTRL);
        wr_sw = reg_wr && (reg_addr == AIC_REG_SW_ALARM);
        wr_lvl = reg_wr && (reg_addr == AIC_REG_PORT_LEVEL);
        wr_st = reg_wr && (reg_addr == AIC_REG_STATUS);
        wr_mask = reg_wr && (reg_addr == AIC_REG_MASK);
        next_delay_s = wr_ctrl ? reg_wdata[AIC_DELAY_W-1:0] : delay_s;
        next_sw_alarm = wr_sw ? reg_wdata[AIC_SW_W-1:0] : sw_alarm;
        next_port_level = wr_lvl ? reg_wdata[AIC_LEVEL_W*NPORTS-1:0] : port_level;
        next_mask = wr_mask ? reg_wdata[AIC_ST_W-1:0] : mask;
        // A set in the same cycle as a write-one clear survives
        next_status = (status & ~(wr_st ? reg_wdata[AIC_ST_W-1:0] : '0)) | st_set;
        next_events = events + fail_rises;
        next_rdata = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                AIC_REG_CTRL: next_rdata = 32'(delay_s);
                AIC_REG_SW_ALARM: next_rdata = 32'(sw_alarm);
                AIC_REG_PORT_LEVEL: next_rdata = 32'(port_level);
                AIC_REG_STATUS: next_rdata = 32'(status);
                AIC_REG_MASK: next_rdata = 32'(mask);
                AIC_REG_STATE: next_rdata = state_word;
                AIC_REG_EVENTS: next_rdata = 32'(events);
                default: next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            delay_s <= AIC_DELAY_RST;
            sw_alarm <= '0;
            port_level <= LEVEL_RST;
            status <= '0;
            mask <= '0;
            events <= '0;
            reg_rdata <= 32'h0;
        end else begin
            delay_s <= next_delay_s;
            sw_alarm <= next_sw_alarm;
            port_level <= next_port_level;
            status <= next_status;
            mask <= next_mask;
            events <= next_events;
            reg_rdata <= next_rdata;
        end
    end

    assign irq = |(status & mask);

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    logic [NALL-1:0] fail_q;
    logic [NALL-1:0] fail_rise;
    logic [1:0] mode_q;
    logic allref_q;

    // Edge history resets to the idle level of each input, so leaving reset
    // with everything healthy raises no event.
    always_comb begin
        fail_rise = {sync_pack_fail, pack_fail} & ~fail_q;
        fail_rises = '0;
        for (int i = 0; i < NALL; i++) begin
            fail_rises = fail_rises + AIC_EVENT_W'(fail_rise[i]);
        end
        st_set = '0;
        st_set[AIC_ST_PACK] = |fail_rise;
        st_set[AIC_ST_FRUN] = (sync_mode == AIC_MODE_FREE_RUN) && (mode_q != sync_mode);
        st_set[AIC_ST_FAST] = (sync_mode == AIC_MODE_FAST) && (mode_q != sync_mode);
        st_set[AIC_ST_HOLD] = (sync_mode == AIC_MODE_HOLDOVER) && (mode_q != sync_mode);
        st_set[AIC_ST_ALLREF] = all_ref_fail && !allref_q;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fail_q <= '0;
            mode_q <= AIC_MODE_NORMAL;
            allref_q <= 1'b0;
        end else begin
            fail_q <= {sync_pack_fail, pack_fail};
            mode_q <= sync_mode;
            allref_q <= all_ref_fail;
        end
    end

    // ------------------------------------------------------------
    // Alarm level gathering and qualification
    // ------------------------------------------------------------
    logic [AIC_SW_W-1:0] raw;
    logic [AIC_SW_W-1:0] qual;
    logic fac_major;
    logic fac_minor;

    // Facility alarms share the software hold-back, so a port whose faults
    // each span fewer ticks than the delay never reaches the closures.
    always_comb begin
        fac_major = 1'b0;
        fac_minor = 1'b0;
        for (int i = 0; i < NPORTS; i++) begin
            if (fac_fail[i]) begin
                // Reserved code reads as no alarm
                fac_major = fac_major ||
                    (port_level[AIC_LEVEL_W*i +: AIC_LEVEL_W] == AIC_LVL_MAJOR);
                fac_minor = fac_minor ||
                    (port_level[AIC_LEVEL_W*i +: AIC_LEVEL_W] == AIC_LVL_MINOR);
            end
        end
        raw = sw_alarm;
        raw[AIC_SW_MAJ] = sw_alarm[AIC_SW_MAJ] || fac_major;
        raw[AIC_SW_MIN] = sw_alarm[AIC_SW_MIN] || fac_minor;
    end

    aic_qualifier #(
        .N(AIC_SW_W)
    ) u_qual (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .tick(tick),
        .delay_s(delay_s),
        .cond(raw),
        .qual(qual)
    );

    // ------------------------------------------------------------
    // Alarm outputs and audible cutoff
    // ------------------------------------------------------------
    aic_alarm_t act;
    aic_alarm_t act_q;
    logic cut_q;
    logic next_cut;
    logic [1:0] cut_in_q;
    logic cut_req;
    logic new_alarm;
    logic next_rid;
    aic_alarm_t next_aud;

    // Cutoff only gates the audible copy; visual and remote follow the alarm.
    always_comb begin
        act.critical = qual[AIC_SW_CRIT];
        act.major = qual[AIC_SW_MAJ];
        act.minor = qual[AIC_SW_MIN];
        act.failure = ctrl_fail;
        // Either source cuts off, on its rising edge
        cut_req = (audible_cutoff_panel && !cut_in_q[0]) ||
                  (audible_cutoff_remote && !cut_in_q[1]);
        new_alarm = |(act & ~act_q);
        // A fresh alarm re-arms the audibles unless a cutoff lands with it
        next_cut = cut_req || (cut_q && !new_alarm);
        next_aud = act & ~{4{next_cut}};
        next_aud.failure = 1'b0;
        next_rid = act.critical || act.major || act.minor || act.failure;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            act_q <= '0;
            cut_q <= 1'b0;
            cut_in_q <= 2'h0;
            remote_alarm <= '0;
            panel_indicator <= '0;
            office_visual <= '0;
            office_audible <= '0;
            remote_id <= 1'b0;
            psu_fault_lamp <= '0;
        end else begin
            act_q <= act;
            cut_q <= next_cut;
            cut_in_q <= {audible_cutoff_remote, audible_cutoff_panel};
            remote_alarm <= act;
            panel_indicator <= act;
            office_visual <= act;
            office_audible <= next_aud;
            remote_id <= next_rid;
            psu_fault_lamp <= psu_fault;
        end
    end

    assign audible_cutoff = cut_q;

    // ------------------------------------------------------------
    // Synchronizer circuit pack lamps
    // ------------------------------------------------------------
    // Pack index = side * 3 + role; side 1 is active when sync_active_side is high.
    // Only the extractors see the mode and the reference blink; the other
    // packs have their active lamp gated by side and failure alone.
    logic mode_ok;
    logic ref_blink;

    assign mode_ok = (sync_mode == AIC_MODE_NORMAL) || (sync_mode == AIC_MODE_FAST);
    assign ref_blink = |ref_fail;

    genvar k;
    generate
        for (k = 0; k < AIC_SYNC_PACKS; k++) begin : g_lamp
            localparam int unsigned SIDE = k / AIC_PACKS_PER_SIDE;
            localparam bit IS_TEX = ((k % AIC_PACKS_PER_SIDE) == AIC_PACK_TEX);
            aic_sync_lamp u_lamp (
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .tick(tick),
                .pack_fail(sync_pack_fail[k]),
                .side_active(sync_active_side == 1'(SIDE)),
                .mode_ok(IS_TEX ? mode_ok : 1'b1),
                .blink_req(IS_TEX ? ref_blink : 1'b0),
                .fault_lamp(fault_lamp[k]),
                .active_lamp(active_lamp[k]),
                .in_service(sync_in_service[k])
            );
        end
    endgenerate

    // Read-only snapshot of the registered alarm outputs and pack service.
    always_comb begin
        state_word = 32'h0;
        state_word[3:0] = act_q;
        state_word[AIC_STATE_RID] = remote_id;
        state_word[AIC_STATE_ACO] = cut_q;
        state_word[AIC_STATE_SVC +: AIC_SYNC_PACKS] = sync_in_service;
    end

endmodule : aic_alarm_ctrl
`default_nettype wire

// File: rtl/aic_pkg.sv
package aic_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned AIC_CLK_PERIOD_NS = 10;
    localparam int unsigned AIC_TICK_PERIOD_NS = 1_000_000_000;
    localparam int unsigned AIC_TICK_CYCLES = AIC_TICK_PERIOD_NS / AIC_CLK_PERIOD_NS;
    localparam int unsigned AIC_QUAL_MIN_S = 1;
    localparam int unsigned AIC_QUAL_MAX_S = 30;
    localparam int unsigned AIC_FAULT_MIN_ON_S = 2;
    localparam int unsigned AIC_BLINK_HALF_S = 1;

    // ------------------------------------------------------------
    // Widths and encodings
    // ------------------------------------------------------------
    localparam int unsigned AIC_DELAY_W = 5;
    localparam int unsigned AIC_LEVEL_W = 2;
    localparam logic [1:0] AIC_LVL_NONE = 2'h0;
    localparam logic [1:0] AIC_LVL_MINOR = 2'h1;
    localparam logic [1:0] AIC_LVL_MAJOR = 2'h2;
    localparam logic [1:0] AIC_MODE_NORMAL = 2'h0;
    localparam logic [1:0] AIC_MODE_FAST = 2'h1;
    localparam logic [1:0] AIC_MODE_FREE_RUN = 2'h2;
    localparam logic [1:0] AIC_MODE_HOLDOVER = 2'h3;
    localparam int unsigned AIC_PACKS_PER_SIDE = 3;
    localparam int unsigned AIC_PACK_PLL = 0;
    localparam int unsigned AIC_PACK_TBO = 1;
    localparam int unsigned AIC_PACK_TEX = 2;
    localparam int unsigned AIC_SYNC_PACKS = 2 * AIC_PACKS_PER_SIDE;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] AIC_REG_CTRL = 8'h00;
    localparam logic [7:0] AIC_REG_SW_ALARM = 8'h04;
    localparam logic [7:0] AIC_REG_PORT_LEVEL = 8'h08;
    localparam logic [7:0] AIC_REG_STATUS = 8'h0C;
    localparam logic [7:0] AIC_REG_MASK = 8'h10;
    localparam logic [7:0] AIC_REG_STATE = 8'h14;
    localparam logic [7:0] AIC_REG_EVENTS = 8'h18;
    localparam logic [AIC_DELAY_W-1:0] AIC_DELAY_RST = 5'h01;
    localparam int unsigned AIC_SW_CRIT = 0;
    localparam int unsigned AIC_SW_MAJ = 1;
    localparam int unsigned AIC_SW_MIN = 2;
    localparam int unsigned AIC_SW_W = 3;
    localparam int unsigned AIC_ST_PACK = 0;
    localparam int unsigned AIC_ST_FRUN = 1;
    localparam int unsigned AIC_ST_FAST = 2;
    localparam int unsigned AIC_ST_HOLD = 3;
    localparam int unsigned AIC_ST_ALLREF = 4;
    localparam int unsigned AIC_ST_W = 5;
    localparam int unsigned AIC_STATE_RID = 4;
    localparam int unsigned AIC_STATE_ACO = 5;
    localparam int unsigned AIC_STATE_SVC = 6;
    localparam int unsigned AIC_EVENT_W = 8;

    typedef struct packed {
        logic critical;
        logic major;
        logic minor;
        logic failure;
    } aic_alarm_t;

endpackage : aic_pkg

// File: rtl/aic_qualifier.sv
`timescale 1ns/100ps
`default_nettype none
module aic_qualifier
    import aic_pkg::*;
#(
    parameter int unsigned N = 3
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic [AIC_DELAY_W-1:0] delay_s,
    input wire logic [N-1:0] cond,
    output logic [N-1:0] qual
);

    // ------------------------------------------------------------
    // Per-condition hold-back counters
    // ------------------------------------------------------------
    // Delay counts whole ticks; the first tick may come early, so a
    // 1 s setting qualifies after between 0 and 1 s of condition.
    logic [AIC_DELAY_W-1:0] lim;

    always_comb begin
        if (delay_s < AIC_DELAY_W'(AIC_QUAL_MIN_S)) begin
            lim = AIC_DELAY_W'(AIC_QUAL_MIN_S);
        end else if (delay_s > AIC_DELAY_W'(AIC_QUAL_MAX_S)) begin
            lim = AIC_DELAY_W'(AIC_QUAL_MAX_S);
        end else begin
            lim = delay_s;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            logic [AIC_DELAY_W-1:0] cnt;
            logic [AIC_DELAY_W-1:0] next_cnt;
            logic hit;
            logic next_hit;

            always_comb begin
                next_cnt = cnt;
                next_hit = hit;
                if (!cond[g]) begin
                    next_cnt = '0;
                    next_hit = 1'b0;
                end else if (!hit && tick) begin
                    if (cnt + 5'h01 >= lim) begin
                        next_hit = 1'b1;
                    end else begin
                        next_cnt = cnt + 5'h01;
                    end
                end
            end

            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt <= '0;
                    hit <= 1'b0;
                end else begin
                    cnt <= next_cnt;
                    hit <= next_hit;
                end
            end

            assign qual[g] = hit;
        end
    endgenerate

endmodule : aic_qualifier
`default_nettype wire

// File: rtl/aic_sync_lamp.sv
`timescale 1ns/100ps
`default_nettype none
module aic_sync_lamp
    import aic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic pack_fail,
    input wire logic side_active,
    input wire logic mode_ok,
    input wire logic blink_req,
    output logic fault_lamp,
    output logic active_lamp,
    output logic in_service
);

    // ------------------------------------------------------------
    // Minimum-on hold and blink phase
    // ------------------------------------------------------------
    // One tick more than the minimum, since the failure may start
    // just before a tick.
    localparam logic [1:0] HOLD_TICKS = 2'(AIC_FAULT_MIN_ON_S + 1);

    logic [1:0] hold;
    logic [1:0] next_hold;
    logic phase;
    logic next_phase;
    logic blink_q;
    logic next_blink_q;
    logic fail_lit;
    logic next_fault;
    logic next_active;
    logic next_svc;

    assign fail_lit = pack_fail || (hold != 2'h0);

    always_comb begin
        next_hold = hold;
        if (pack_fail) begin
            next_hold = HOLD_TICKS;
        end else if (tick && hold != 2'h0) begin
            next_hold = hold - 2'h1;
        end
        next_blink_q = blink_req;
        next_phase = phase;
        if (!blink_req) begin
            next_phase = 1'b0;
        end else if (!blink_q) begin
            next_phase = 1'b1;
        end else if (tick) begin
            next_phase = !phase;
        end
        next_fault = fail_lit || next_phase;
        next_active = side_active && mode_ok && !fail_lit;
        next_svc = !fail_lit;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold <= 2'h0;
            phase <= 1'b0;
            blink_q <= 1'b0;
            fault_lamp <= 1'b0;
            active_lamp <= 1'b0;
            in_service <= 1'b0;
        end else begin
            hold <= next_hold;
            phase <= next_phase;
            blink_q <= next_blink_q;
            fault_lamp <= next_fault;
            active_lamp <= next_active;
            in_service <= next_svc;
        end
    end

endmodule : aic_sync_lamp
`default_nettype wire

// File: verification/aic_panel_model.sv
`timescale 1ns/100ps
`default_nettype none
module aic_panel_model (
    input wire logic ref_clk,
    input wire logic press,
    input wire logic from_remote,
    output logic audible_cutoff_panel,
    output logic audible_cutoff_remote
);
    // Held pushbutton: the contact stays closed four cycles, then opens
    logic [2:0] held = 3'h0;
    always @(posedge ref_clk) begin
        if (press) held <= 3'h4;
        else if (held != 3'h0) held <= held - 3'h1;
    end
    assign audible_cutoff_panel = (held != 3'h0) && !from_remote;
    assign audible_cutoff_remote = (held != 3'h0) && from_remote;
endmodule : aic_panel_model
`default_nettype wire

// File: verification/aic_alarm_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module aic_alarm_ctrl_checker
    import aic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ctrl_fail,
    input wire logic audible_cutoff_panel,
    input wire logic audible_cutoff_remote,
    input wire logic [AIC_SYNC_PACKS-1:0] sync_pack_fail,
    input wire logic [1:0] sync_mode,
    input wire logic [1:0] ref_fail,
    input wire logic [AIC_SYNC_PACKS-1:0] fault_lamp,
    input wire logic [AIC_SYNC_PACKS-1:0] active_lamp,
    input wire logic [AIC_SYNC_PACKS-1:0] sync_in_service,
    input wire aic_alarm_t remote_alarm,
    input wire aic_alarm_t panel_indicator,
    input wire aic_alarm_t office_audible,
    input wire logic remote_id,
    input wire logic audible_cutoff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    property p_mirror; panel_indicator == remote_alarm; endproperty
    a_mirror: assert property (p_mirror) else $error("panel differs");
    property p_rid; remote_id == (remote_alarm != 4'h0); endproperty
    a_rid: assert property (p_rid) else $error("remote id wrong");
    property p_no_aud; !office_audible.failure; endproperty
    a_no_aud: assert property (p_no_aud) else $error("failure audible");
    property p_ctrl; ctrl_fail |=> remote_alarm.failure; endproperty
    a_ctrl: assert property (p_ctrl) else $error("failure late");
    property p_fault;
        sync_pack_fail[0] |=> fault_lamp[0] && !active_lamp[0] && !sync_in_service[0];
    endproperty
    a_fault: assert property (p_fault) else $error("fault lamp");
    property p_blink; $rose(ref_fail[0]) && !ref_fail[1] |=> fault_lamp[AIC_PACK_TEX]; endproperty
    a_blink: assert property (p_blink) else $error("blink late");
    property p_tex;
        sync_mode[1] |=> !active_lamp[AIC_PACK_TEX] && !active_lamp[AIC_PACK_TEX + 3];
    endproperty
    a_tex: assert property (p_tex) else $error("extractor lamp");
    property p_aco;
        $rose(audible_cutoff_panel) || $rose(audible_cutoff_remote) |=> audible_cutoff;
    endproperty
    a_aco: assert property (p_aco) else $error("cutoff missed");
endmodule : aic_alarm_ctrl_checker
`default_nettype wire

// File: verification/aic_alarm_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module aic_alarm_ctrl_tb
    import aic_pkg::*;
;
    localparam int TK = 20;
    logic ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ctrl_fail = 1'b0;
    logic press = 1'b0, from_remote = 1'b0, sync_active_side = 1'b0, all_ref_fail = 1'b0;
    logic [7:0] reg_addr = 8'h00, pack_fail = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [11:0] fac_fail = 12'h000;
    logic [1:0] psu_fault = 2'h0, sync_mode = 2'h0, ref_fail = 2'h0, psu_fault_lamp;
    logic [5:0] sync_pack_fail = 6'h00, fault_lamp, active_lamp, sync_in_service;
    logic audible_cutoff_panel, audible_cutoff_remote, remote_id, audible_cutoff, irq;
    aic_alarm_t remote_alarm, panel_indicator, office_visual, office_audible;
    int fail_count = 0;
    int checked = 0;
    always #5 ref_clk = ~ref_clk;
    aic_alarm_ctrl #(.TICK_CYCLES(TK)) dut (
        .ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fac_fail,
        .ctrl_fail, .audible_cutoff_panel, .audible_cutoff_remote, .pack_fail, .psu_fault,
        .psu_fault_lamp, .sync_pack_fail, .sync_active_side, .sync_mode, .ref_fail,
        .all_ref_fail, .fault_lamp, .active_lamp, .sync_in_service, .remote_alarm,
        .panel_indicator, .office_visual, .office_audible, .remote_id, .audible_cutoff, .irq
    );
    aic_panel_model model (
        .ref_clk, .press, .from_remote, .audible_cutoff_panel, .audible_cutoff_remote
    );
    task automatic results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Outputs are looked at on the falling edge, well clear of updates
    task automatic look(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : look
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata, e);
    endtask : rd
    task automatic wait_al(input int i, input int lim);
        int n;
        for (n = 0; n < lim && remote_alarm[i] !== 1'b1; n++) @(negedge ref_clk);
        if (n == lim) begin
            fail_count++;
            $display("ERROR %0t alarm wait timed out", $time);
            results();
        end
    endtask : wait_al
    initial begin
        repeat (50000) @(posedge ref_clk);
        fail_count++;
        $display("ERROR %0t run timed out", $time);
        results();
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(AIC_REG_CTRL, 32'h1);
        rd(AIC_REG_PORT_LEVEL, 32'hAA0000);
        rd(8'h1C, 32'h0);
        @(posedge ref_clk);
        fac_fail <= 12'h101;
        wait_al(2, 2 * TK);
        chk(remote_alarm, 4'h4);
        wr(AIC_REG_PORT_LEVEL, 32'hAA0001);
        wait_al(1, 2 * TK);
        chk(remote_id, 1'b1);
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk);
            from_remote <= s[0];
            press <= 1'b1;
            @(posedge ref_clk);
            press <= 1'b0;
            look(3);
            chk({audible_cutoff, office_audible}, 5'h10);
            chk(office_visual, {3'h3, s[0]});
            @(posedge ref_clk);
            ctrl_fail <= !s[0];
            look(4);
            chk(office_audible, s ? 4'h0 : 4'h6);
        end
        @(posedge ref_clk);
        fac_fail <= 12'h000;
        look(3);
        chk(remote_id, 1'b0);
        // Drop the request late in its delay: the count must start over
        wr(AIC_REG_CTRL, 32'h3);
        wr(AIC_REG_SW_ALARM, 32'h1);
        look(2 * TK - 6);
        chk(remote_alarm.critical, 1'b0);
        wr(AIC_REG_SW_ALARM, 32'h0);
        wr(AIC_REG_SW_ALARM, 32'h1);
        look(TK + 8);
        chk(remote_alarm.critical, 1'b0);
        wait_al(3, 2 * TK + 5);
        chk(active_lamp, 6'h07);
        @(posedge ref_clk);
        sync_active_side <= 1'b1;
        sync_mode <= AIC_MODE_FREE_RUN;
        look(2);
        chk(active_lamp, 6'h18);
        @(posedge ref_clk);
        sync_mode <= AIC_MODE_HOLDOVER;
        @(posedge ref_clk);
        sync_mode <= AIC_MODE_FAST;
        all_ref_fail <= 1'b1;
        sync_pack_fail <= 6'h01;
        pack_fail <= 8'h80;
        @(posedge ref_clk);
        sync_pack_fail <= 6'h00;
        look(1);
        chk(active_lamp, 6'h38);
        look(2 * TK);
        chk({fault_lamp[0], sync_in_service[0]}, 2'h2);
        look(2 * TK);
        chk({fault_lamp, sync_in_service}, 12'h03F);
        rd(AIC_REG_EVENTS, 32'h2);
        rd(AIC_REG_STATUS, 32'h1F);
        chk(irq, 1'b0);
        wr(AIC_REG_MASK, 32'h1);
        look(1);
        chk(irq, 1'b1);
        wr(AIC_REG_STATUS, 32'h1);
        rd(AIC_REG_STATUS, 32'h1E);
        rd(AIC_REG_STATE, 32'hFD8);
        chk(irq, 1'b0);
        @(posedge ref_clk);
        ref_fail <= 2'h1;
        psu_fault <= 2'h2;
        look(1);
        chk({fault_lamp[2], psu_fault_lamp}, 3'h6);
        look(TK);
        chk(fault_lamp[2], 1'b0);
        look(TK);
        chk(fault_lamp[2], 1'b1);
        @(posedge ref_clk);
        ref_fail <= 2'h0;
        look(2);
        chk(fault_lamp[2], 1'b0);
        results();
    end
endmodule : aic_alarm_ctrl_tb
bind aic_alarm_ctrl aic_alarm_ctrl_checker chk_u (
    .ref_clk, .rst_b, .ctrl_fail, .audible_cutoff_panel, .audible_cutoff_remote,
    .sync_pack_fail, .sync_mode, .ref_fail, .fault_lamp, .active_lamp, .sync_in_service,
    .remote_alarm, .panel_indicator, .office_audible, .remote_id, .audible_cutoff
);
`default_nettype wire
